// ---- logic/poll_sched_pkg.sv ----
// constants and carriers for the timed poll scheduler
// assumes a 40 MHz clock and a plain register port
package poll_sched_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int PENALTY_MS = 2000;
  localparam int PENALTY_TICKS = PENALTY_MS / TICK_MS;
  localparam int MAX_LEN = 128;
  localparam int MBOX_MAX = 2048;
  localparam int LOC_GAP_LO = 32;
  localparam int LOC_GAP_HI = 65;
  localparam int TABLE_DEPTH = 48;
  // register indices
  localparam logic [7:0] REG_INTERVAL = 8'h00;
  localparam logic [7:0] REG_ROUTE = 8'h01;
  localparam logic [7:0] REG_RD_LEN = 8'h02;
  localparam logic [7:0] REG_RD_SRC = 8'h03;
  localparam logic [7:0] REG_RD_DST = 8'h04;
  localparam logic [7:0] REG_WR_LEN = 8'h05;
  localparam logic [7:0] REG_WR_SRC = 8'h06;
  localparam logic [7:0] REG_WR_DST = 8'h07;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h09;
  localparam logic [7:0] REG_TBL_IDX = 8'h0a;
  localparam logic [7:0] REG_TBL_LOC = 8'h0b;
  localparam logic [7:0] REG_TBL_REM = 8'h0c;
  localparam logic [7:0] REG_TBL_LEN = 8'h0d;
  localparam logic [7:0] REG_TBL_DIR = 8'h0e;
  localparam logic [7:0] REG_TBL_RTE = 8'h0f;
  // control bits
  localparam int CTRL_NET_PORT = 0;
  localparam int CTRL_PEER_EN = 1;
  localparam int CTRL_POLL_PROTO = 2;

  typedef struct packed {
    logic [11:0] local_ptr;
    logic [15:0] remote_ptr;
    logic [7:0] len;
    logic dir_write;
    logic [7:0] route;
  } scan_entry_t;

  typedef struct packed {
    logic write;
    logic [7:0] route;
    logic [15:0] remote_start;
    logic [11:0] local_start;
    logic [7:0] len;
    logic from_table;
    logic [5:0] entry;
  } msg_req_t;
endpackage : poll_sched_pkg

// ---- logic/timed_poll_scheduler.sv ----
// timed poll scheduler: single-transfer engine plus 48-entry scan table
// assumes a message engine that takes o_msg on valid and reports replies
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module timed_poll_scheduler import poll_sched_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int DEPTH = TABLE_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output msg_req_t o_msg,
  output logic o_msg_valid,
  input wire logic i_msg_ready,
  input wire logic i_reply_done,
  output logic o_master_mode,
  output logic o_slave_refused,
  output logic o_busy
);
  typedef enum {ST_IDLE, ST_WAIT, ST_PENALTY} sched_state_t;

  logic [15:0] interval;
  logic [7:0] route;
  logic [7:0] rd_len;
  logic [15:0] rd_src;
  logic [11:0] read_dest_start;
  logic [7:0] wr_len;
  logic [11:0] wr_src;
  logic [15:0] write_dest_start;
  logic [2:0] ctrl;
  logic [5:0] tbl_idx;
  scan_entry_t table_mem [DEPTH];
  logic [DEPTH-1:0] entry_ok;
  logic [5:0] cursor;
  logic next_is_write;
  logic awaiting_reply;
  logic [23:0] tick_cnt;
  logic tick;
  logic [15:0] ticks_left;
  sched_state_t state;
  logic table_active;
  logic single_allowed;
  logic single_rd_ok;
  logic single_wr_ok;
  logic [5:0] next_cursor;
  logic found;

  logic accept;
  logic launch_table;
  logic launch_single;
  logic pick_write;
  msg_req_t next_msg;
  sched_state_t next_state;
  logic [15:0] next_ticks_left;
  logic [23:0] next_tick_cnt;

  logic [DEPTH-1:0] loc_ok;
  logic [DEPTH-1:0] rem_ok;
  logic [DEPTH-1:0] cnt_ok;
  logic [DEPTH-1:0] rte_ok;

  // 12 bits so the top mailbox location 2048 is reachable
  function automatic logic local_ok(input logic [11:0] p);
    local_ok = (p != 12'h000) &&
      ((p <= 12'(LOC_GAP_LO)) || ((p >= 12'(LOC_GAP_HI)) && (p <= 12'(MBOX_MAX))));
  endfunction : local_ok

  function automatic logic len_ok(input logic [7:0] n);
    len_ok = (n != 8'h00) && (n <= 8'(MAX_LEN));
  endfunction : len_ok

  // entry validity, one checker per slot
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_valid
      assign loc_ok[g] = local_ok(table_mem[g].local_ptr);
      assign rem_ok[g] = (table_mem[g].remote_ptr != 16'h0000);
      assign cnt_ok[g] = len_ok(table_mem[g].len);
      assign rte_ok[g] = (table_mem[g].route != 8'h00);
      // a zero in the local, remote, length or route field parks the entry without clearing the rest
      assign entry_ok[g] = loc_ok[g] && rem_ok[g] && cnt_ok[g] && rte_ok[g];
    end
  endgenerate

  assign table_active = (interval != 16'h0000) && (|entry_ok);
  // table takes the shared interval; network port needs peer off
  assign single_allowed = (interval != 16'h0000) && !(|entry_ok) &&
    !(ctrl[CTRL_NET_PORT] && ctrl[CTRL_PEER_EN]);
  assign single_rd_ok = len_ok(rd_len) && (read_dest_start != 12'h000) &&
    (read_dest_start <= 12'(MBOX_MAX));
  assign single_wr_ok = len_ok(wr_len);
  assign o_master_mode = ctrl[CTRL_POLL_PROTO] &&
    (table_active || (single_allowed && (single_rd_ok || single_wr_ok)));
  assign o_slave_refused = ctrl[CTRL_POLL_PROTO] && table_active;
  assign o_busy = (state != ST_IDLE) || awaiting_reply;

  // configuration writes: pacing interval
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      interval <= 16'h0000;
    end else if (i_wr && (i_addr == REG_INTERVAL)) begin
      interval <= i_wdata;
    end
  end

  // single-transfer settings
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      route <= 8'h00;
      rd_len <= 8'h00;
      rd_src <= 16'h0000;
      read_dest_start <= 12'h000;
      wr_len <= 8'h00;
      wr_src <= 12'h000;
      write_dest_start <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        REG_ROUTE: route <= i_wdata[7:0];
        REG_RD_LEN: rd_len <= i_wdata[7:0];
        REG_RD_SRC: rd_src <= i_wdata;
        REG_RD_DST: read_dest_start <= i_wdata[11:0];
        REG_WR_LEN: wr_len <= i_wdata[7:0];
        REG_WR_SRC: wr_src <= i_wdata[11:0];
        REG_WR_DST: write_dest_start <= i_wdata;
        default: ;
      endcase
    end
  end

  // port control and table index
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl <= 3'h0;
      tbl_idx <= 6'h00;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL: ctrl <= i_wdata[2:0];
        REG_TBL_IDX: tbl_idx <= i_wdata[5:0];
        default: ;
      endcase
    end
  end

  // table store, written through the index window
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int k = 0; k < DEPTH; k++) begin
        table_mem[k] <= '0;
      end
    end else if (i_wr && (32'(tbl_idx) < DEPTH)) begin
      case (i_addr)
        REG_TBL_LOC: table_mem[tbl_idx].local_ptr <= i_wdata[11:0];
        REG_TBL_REM: table_mem[tbl_idx].remote_ptr <= i_wdata;
        REG_TBL_LEN: table_mem[tbl_idx].len <= i_wdata[7:0];
        REG_TBL_DIR: table_mem[tbl_idx].dir_write <= i_wdata[0];
        REG_TBL_RTE: table_mem[tbl_idx].route <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        REG_INTERVAL: o_rdata <= interval;
        REG_ROUTE: o_rdata <= {8'h00, route};
        REG_RD_LEN: o_rdata <= {8'h00, rd_len};
        REG_RD_SRC: o_rdata <= rd_src;
        REG_RD_DST: o_rdata <= {4'h0, read_dest_start};
        REG_WR_LEN: o_rdata <= {8'h00, wr_len};
        REG_WR_SRC: o_rdata <= {4'h0, wr_src};
        REG_WR_DST: o_rdata <= write_dest_start;
        REG_CTRL: o_rdata <= {13'h0000, ctrl};
        REG_STATUS: o_rdata <= {8'h00, cursor, table_active, awaiting_reply};
        REG_TBL_IDX: o_rdata <= {10'h000, tbl_idx};
        REG_TBL_LOC: o_rdata <= {4'h0, table_mem[tbl_idx].local_ptr};
        REG_TBL_REM: o_rdata <= table_mem[tbl_idx].remote_ptr;
        REG_TBL_LEN: o_rdata <= {8'h00, table_mem[tbl_idx].len};
        REG_TBL_DIR: o_rdata <= {15'h0000, table_mem[tbl_idx].dir_write};
        REG_TBL_RTE: o_rdata <= {8'h00, table_mem[tbl_idx].route};
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // 10 ms tick enable; one-cycle pulse so every timer shares the one clock
  assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));
  always_comb begin
    if (tick) begin
      next_tick_cnt = 24'h000000;
    end else begin
      next_tick_cnt = tick_cnt + 24'h000001;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // next valid entry after the cursor, ascending with wrap
  always_comb begin
    next_cursor = cursor;
    found = 1'b0;
    for (int k = 1; k <= DEPTH; k++) begin
      if (!found && entry_ok[(32'(cursor) + k) % DEPTH]) begin
        next_cursor = 6'((32'(cursor) + k) % DEPTH);
        found = 1'b1;
      end
    end
  end

  // launch decisions; the table wins whenever any entry is valid
  assign accept = o_msg_valid && i_msg_ready;
  assign launch_table = (state == ST_IDLE) && !o_msg_valid && table_active && found;
  assign launch_single = (state == ST_IDLE) && !o_msg_valid && !launch_table &&
    single_allowed && (single_rd_ok || single_wr_ok);
  // alternate only when both directions are live
  assign pick_write = (next_is_write && single_wr_ok) || !single_rd_ok;

  function automatic msg_req_t table_msg(input scan_entry_t e, input logic [5:0] idx);
    msg_req_t m;
    m.write = e.dir_write;
    m.route = e.route;
    m.remote_start = e.remote_ptr;
    m.local_start = e.local_ptr;
    m.len = e.len;
    m.from_table = 1'b1;
    m.entry = idx;
    table_msg = m;
  endfunction : table_msg

  // single-transfer request; the read leg lands at read_dest_start
  function automatic msg_req_t single_msg(
    input logic as_write,
    input logic [7:0] rte,
    input logic [15:0] rd_remote,
    input logic [11:0] rd_local,
    input logic [7:0] rd_cnt,
    input logic [15:0] wr_remote,
    input logic [11:0] wr_local,
    input logic [7:0] wr_cnt
  );
    msg_req_t m;
    m.write = as_write;
    m.route = rte;
    if (as_write) begin
      m.remote_start = wr_remote;
      m.local_start = wr_local;
      m.len = wr_cnt;
    end else begin
      m.remote_start = rd_remote;
      m.local_start = rd_local;
      m.len = rd_cnt;
    end
    m.from_table = 1'b0;
    m.entry = 6'h00;
    single_msg = m;
  endfunction : single_msg

  // contents load only at launch, so they hold until accepted
  always_comb begin
    next_msg = o_msg;
    if (launch_table) begin
      next_msg = table_msg(table_mem[next_cursor], next_cursor);
    end else if (launch_single) begin
      next_msg = single_msg(pick_write, route, rd_src, read_dest_start, rd_len,
        write_dest_start, wr_src, wr_len);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_msg <= '0;
    end else begin
      o_msg <= next_msg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_msg_valid <= 1'b0;
    end else if (launch_table || launch_single) begin
      o_msg_valid <= 1'b1;
    end else if (accept) begin
      o_msg_valid <= 1'b0;
    end
  end

  // cursor parks on the last entry sent, so the walk resumes after it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cursor <= 6'(DEPTH - 1);
    end else if (launch_table) begin
      cursor <= next_cursor;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      next_is_write <= 1'b0;
    end else if (launch_single) begin
      next_is_write <= !pick_write;
    end
  end

  // reply wins if it lands with a new send
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      awaiting_reply <= 1'b0;
    end else if (i_reply_done) begin
      awaiting_reply <= 1'b0;
    end else if (accept) begin
      awaiting_reply <= 1'b1;
    end
  end

  // interval and penalty countdown in tick units
  always_comb begin
    next_state = state;
    next_ticks_left = ticks_left;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_WAIT;
          next_ticks_left = interval;
        end
      end
      ST_WAIT: begin
        if (interval == 16'h0000) begin
          next_state = ST_IDLE;
        end else if (tick) begin
          if (ticks_left > 16'h0001) begin
            next_ticks_left = ticks_left - 16'h0001;
          end else if (awaiting_reply && !i_reply_done) begin
            next_state = ST_PENALTY;
            next_ticks_left = 16'(PENALTY_TICKS);
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_PENALTY: begin
        // the late reply is abandoned after the extra wait
        if (interval == 16'h0000) begin
          next_state = ST_IDLE;
        end else if (tick) begin
          if (ticks_left > 16'h0001) begin
            next_ticks_left = ticks_left - 16'h0001;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      ticks_left <= 16'h0000;
    end else begin
      state <= next_state;
      ticks_left <= next_ticks_left;
    end
  end
endmodule : timed_poll_scheduler

// ---- testbench/timed_poll_scheduler_asserts.sv ----
// port checker for the timed poll scheduler
// assumes interval and control reach the block only by register writes
`timescale 1ns/1ps
module timed_poll_scheduler_asserts import poll_sched_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire msg_req_t o_msg,
  input wire logic o_msg_valid,
  input wire logic i_msg_ready,
  input wire logic i_reply_done,
  input wire logic o_master_mode,
  input wire logic o_slave_refused
);
  logic [15:0] ivl;
  logic [2:0] ctl;
  logic waiting;
  logic late;
  logic seen;
  int gap;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // shadow copies, so spacing is judged against what software set
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ivl <= '0;
      ctl <= '0;
    end else if (i_wr && i_addr == REG_INTERVAL) begin
      ivl <= i_wdata;
    end else if (i_wr && i_addr == REG_CTRL) begin
      ctl <= i_wdata[2:0];
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || (o_msg_valid && i_msg_ready)) begin
      gap <= 0;
      late <= 1'b0;
    end else begin
      gap <= gap + 1;
      if (waiting && gap == (ivl + 1) * TICK_CYCLES) begin
        late <= 1'b1;
      end
    end
  end
  // a fresh interval setting restarts the spacing reference
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || (i_wr && i_addr == REG_INTERVAL)) begin
      seen <= 1'b0;
    end else if (o_msg_valid && i_msg_ready) begin
      seen <= 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_reply_done) begin
      waiting <= 1'b0;
    end else if (o_msg_valid && i_msg_ready) begin
      waiting <= 1'b1;
    end
  end
  sequence s_stall;
    o_msg_valid && !i_msg_ready;
  endsequence
  sequence s_launch;
    $rose(o_msg_valid) && seen;
  endsequence
  a_msg_holds: assert property (s_stall |=> o_msg_valid && $stable(o_msg))
    else $error("request dropped or changed before acceptance");
  a_zero_interval: assert property ($rose(o_msg_valid) |-> ivl != 0)
    else $error("request raised with zero interval");
  a_msg_spacing: assert property (s_launch |-> gap >= (ivl - 1) * TICK_CYCLES)
    else $error("requests closer than the interval");
  a_late_penalty: assert property (s_launch and late |-> gap >= (ivl + 199) * TICK_CYCLES)
    else $error("late reply without the long wait");
  a_len_range: assert property (o_msg_valid |-> o_msg.len inside {[1:128]})
    else $error("request length out of range");
  a_read_dest: assert property (o_msg_valid && !o_msg.from_table && !o_msg.write
    |-> o_msg.local_start inside {[1:2048]})
    else $error("single read destination out of range");
  a_table_ptrs: assert property (o_msg_valid && o_msg.from_table
    |-> o_msg.local_start inside {[1:32], [65:2048]} && o_msg.remote_start != 0
    && o_msg.route != 0 && o_msg.entry < 48)
    else $error("table request from an invalid entry");
  a_peer_block: assert property ($rose(o_msg_valid) && !o_msg.from_table
    |-> !(ctl[0] && ctl[1]))
    else $error("single transfer on network port with peer feature on");
  a_refuse_master: assert property (o_slave_refused |-> o_master_mode && ctl[2])
    else $error("slave refused without master poll mode");
endmodule : timed_poll_scheduler_asserts
bind timed_poll_scheduler timed_poll_scheduler_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .o_msg(o_msg), .o_msg_valid(o_msg_valid), .i_msg_ready(i_msg_ready),
  .i_reply_done(i_reply_done), .o_master_mode(o_master_mode),
  .o_slave_refused(o_slave_refused));

// ---- testbench/remote_slave_model.sv ----
// remote device stand-in: takes requests with random stalls, replies later
// assumes one outstanding request at a time
`timescale 1ns/1ps
module remote_slave_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_msg_valid,
  input wire logic i_slow,
  output logic o_msg_ready,
  output logic o_reply_done
);
  int seed = 32'h7fc1;
  int wait_cnt;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_msg_ready <= 1'b0;
      o_reply_done <= 1'b0;
      wait_cnt <= 0;
    end else begin
      o_msg_ready <= ($random(seed) & 1) != 0;
      o_reply_done <= !(i_msg_valid && o_msg_ready) && (wait_cnt == 1);
      // prompt replies land well inside the interval; slow ones miss it
      if (i_msg_valid && o_msg_ready) begin
        wait_cnt <= i_slow ? 60 : 3;
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : remote_slave_model

// ---- testbench/timed_poll_scheduler_tb.sv ----
// self-checking bench for the timed poll scheduler
// assumes a 4-cycle tick and the stalling remote model
`timescale 1ns/1ps
module timed_poll_scheduler_tb import poll_sched_pkg::*; ;
  logic sys_clk = 0, rst = 1, wr = 0, rd = 0, slow = 0, rd_pend = 0;
  logic [7:0] addr = '0;
  logic [15:0] wdata = '0, rdata, rsrc, wdst, trem;
  logic msg_valid, msg_ready, reply_done, master_mode, slave_refused, busy, rv, wv;
  logic [1:0] mm;
  msg_req_t msg;
  logic [15:0] rq[$];
  msg_req_t mq[$];
  int seed = 32'h7fc1, fails = 0, total_checks = 0;
  logic [15:0] rl[7] = '{4, 0, 128, 4, 4, 4, 129};
  logic [15:0] rdst[7] = '{5, 5, 2048, 0, 2049, 5, 5};
  logic [15:0] wl[7] = '{2, 128, 0, 2, 0, 2, 0};
  logic [15:0] ct[7] = '{4, 4, 4, 4, 4, 3, 4};
  timed_poll_scheduler #(.TICK_CYCLES(4)) u_timed_poll_scheduler (.i_sys_clk(sys_clk),
    .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_msg(msg), .o_msg_valid(msg_valid), .i_msg_ready(msg_ready), .i_reply_done(reply_done),
    .o_master_mode(master_mode), .o_slave_refused(slave_refused), .o_busy(busy));
  remote_slave_model u_remote_slave_model (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_msg_valid(msg_valid), .i_slow(slow), .o_msg_ready(msg_ready), .o_reply_done(reply_done));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  function automatic logic [63:0] mask(input msg_req_t m);
    if (!m.from_table) m.entry = '0;
    return 64'(m);
  endfunction : mask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {addr, wdata, wr, rd} <= {a, d, 2'b10};
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    {addr, wr, rd} <= {a, 2'b01};
    rq.push_back(exp);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic ent(input logic [15:0] i, loc, rem, len, dir, rte);
    wr_reg(REG_TBL_IDX, i);
    wr_reg(REG_TBL_LOC, loc);
    wr_reg(REG_TBL_REM, rem);
    wr_reg(REG_TBL_LEN, len);
    wr_reg(REG_TBL_DIR, dir);
    wr_reg(REG_TBL_RTE, rte);
  endtask : ent
  // waits out the expected requests, then stops the engines
  task automatic drain(input int n);
    wr_reg(REG_INTERVAL, 16'h0003);
    for (int i = 0; i < 6000 && mq.size() > 0; i++) @(posedge sys_clk);
    chk("pending", mq.size(), 0);
    // port role while the engine is still enabled
    mm = {master_mode, slave_refused};
    if (n == 0) repeat (60) @(posedge sys_clk);
    wr_reg(REG_INTERVAL, 16'h0000);
    @(posedge sys_clk);
    {wr, rd} <= 2'b00;
    repeat (80) @(posedge sys_clk);
  endtask : drain
  always @(posedge sys_clk) begin
    if (rd_pend) chk("rdata", rdata, rq.pop_front());
    rd_pend <= rd;
    if (msg_valid && msg_ready) begin
      if (mq.size() == 0) chk("extra request", 1, 0);
      else chk("request", mask(msg), mask(mq.pop_front()));
    end
  end
  initial begin
    #(25 * 60000);
    fails++;
    complete_run;
  end
  initial begin
    rsrc = $random(seed) | 1;
    wdst = $random(seed) | 1;
    trem = $random(seed) | 1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(REG_STATUS, 16'h00bc);
    rd_reg(8'h20, 16'h0000);
    wr_reg(REG_ROUTE, 16'h0009);
    wr_reg(REG_RD_SRC, rsrc);
    wr_reg(REG_WR_SRC, 16'h0007);
    wr_reg(REG_WR_DST, wdst);
    for (int c = 0; c < 7; c++) begin
      wr_reg(REG_RD_LEN, rl[c]);
      wr_reg(REG_RD_DST, rdst[c]);
      wr_reg(REG_WR_LEN, wl[c]);
      wr_reg(REG_CTRL, ct[c]);
      rv = rl[c] inside {[1:128]} && rdst[c] inside {[1:2048]};
      wv = wl[c] inside {[1:128]};
      slow <= c == 0;
      for (int k = 0; k < 4; k++) begin
        if ((rv || wv) && ct[c] != 3) begin
          if (rv && (!wv || k % 2 == 0)) mq.push_back('{0, 9, rsrc, rdst[c], rl[c], 0, 0});
          else mq.push_back('{1, 9, wdst, 7, wl[c], 0, 0});
        end
      end
      drain(mq.size());
      if (c == 0) chk("master", mm, 2'b10);
      $display("test single case %0d done", c);
    end
    wr_reg(REG_RD_LEN, 16'h0004);
    wr_reg(REG_RD_DST, 16'h0005);
    wr_reg(REG_CTRL, 16'h0004);
    ent(0, 40, 5, 3, 0, 1);
    ent(1, 2048, trem, 128, 0, 3);
    ent(2, 80, 0, 3, 1, 3);
    ent(3, 90, 4, 0, 1, 3);
    ent(4, 95, 4, 2, 1, 0);
    ent(47, 32, 16'hffff, 1, 1, 4);
    ent(48, 100, 1, 1, 0, 1);
    for (int k = 0; k < 2; k++) begin
      mq.push_back('{0, 3, trem, 2048, 128, 1, 1});
      mq.push_back('{1, 4, 16'hffff, 32, 1, 1, 47});
    end
    drain(4);
    chk("refused", mm, 2'b11);
    $display("test scan table done");
    complete_run;
  end
endmodule : timed_poll_scheduler_tb
